/* inc/adc_fmt_defs.vh */
// Register offsets, field positions and codes of the converter output formatting block.
`ifndef ADC_FMT_DEFS_VH
`define ADC_FMT_DEFS_VH

`define OUTPUT_MODE_CFG_ADDR   8'h03
`define DATA_FORMAT_CTRL_ADDR  8'h04

`define OUTPUT_MODE_CFG_RST    8'h00
`define DATA_FORMAT_CTRL_RST   8'h00

`define OM_DISABLE_BIT         2
`define OM_MODE_HI             1
`define OM_MODE_LO             0

`define DF_TEST_HI             5
`define DF_TEST_LO             3
`define DF_ABP_BIT             2
`define DF_RANDOMIZER_ENABLE_BIT            1
`define DF_TWOS_BIT            0

`define MODE_FULL_CMOS         2'h0
`define MODE_DDR_LVDS          2'h1
`define MODE_DDR_CMOS          2'h2

`define TEST_OFF               3'h0
`define TEST_ZEROS             3'h1
`define TEST_ONES              3'h3
`define TEST_CHECKER           3'h5
`define TEST_TOGGLE            3'h7

`define CHECKER_A              17'h15555
`define CHECKER_B              17'h0aaaa

`endif

/* rtl/out_skid_buffer.v */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/100ps
module out_skid_buffer #(
    parameter WIDTH = 17
) (
    // Clock and reset.
    input  wire             core_clk_i,
    input  wire             sys_rst_i,
    // Filling side.
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // Draining side.
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_reg [0:1];
    reg             wr_ptr_reg;
    reg             rd_ptr_reg;
    reg [1:0]       count_reg;

    wire push = in_valid_i && in_ready_o;
    wire pop  = out_valid_o && out_ready_i;

    assign in_ready_o  = (count_reg != 2'h2);
    assign out_valid_o = (count_reg != 2'h0);
    assign out_data_o  = mem_reg[rd_ptr_reg];

    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end

    // Storage needs no reset; valid is governed by the count alone.
    always @(posedge core_clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end
endmodule // out_skid_buffer

/* rtl/adc_output_format_control.v */
// Output word formatting and its configuration registers for a 16-bit converter.
`timescale 1ns/100ps
`include "adc_fmt_defs.vh"

module adc_output_format_control #(
    parameter DATA_W = 16
) (
    // Clock and reset.
    input  wire              core_clk_i,
    input  wire              sys_rst_i,
    // Register port.
    input  wire [7:0]        cfg_addr_i,
    input  wire              cfg_wr_i,
    input  wire [7:0]        cfg_wdata_i,
    output reg  [7:0]        cfg_rdata_o,
    // Converted samples, offset binary from the core.
    input  wire              sample_valid_i,
    output wire              sample_ready_o,
    input  wire [DATA_W-1:0] sample_bits_i,
    input  wire              overflow_flag_i,
    // Output pins, enable low while driven.
    output reg  [DATA_W-1:0] sample_bits_o,
    output reg               overflow_flag_o,
    output wire [DATA_W:0]   pin_oe_n_o,
    output wire              word_valid_o,
    input  wire              word_ready_i,
    output wire [1:0]        output_mode_o
);
    // Register select codes returned by the address decode.
    localparam SEL_NONE   = 2'b00;
    localparam SEL_MODE   = 2'b01;
    localparam SEL_FORMAT = 2'b10;

    // One-hot pattern phases; reset loads phase A, and selecting a checkerboard or toggle run does not restart the phase.
    localparam PHASE_A    = 2'b01;
    localparam PHASE_B    = 2'b10;

    reg  [7:0]        output_mode_cfg_reg;
    reg  [7:0]        data_format_control_reg;
    reg  [1:0]        phase_reg;
    reg  [1:0]        phase_next;
    reg  [DATA_W:0]   word_next;

    wire              output_disable      = output_mode_cfg_reg[`OM_DISABLE_BIT];
    wire              output_mode_sel_hi  = output_mode_cfg_reg[`OM_MODE_HI];
    wire              output_mode_sel_lo  = output_mode_cfg_reg[`OM_MODE_LO];
    wire [2:0]        test_sel            = data_format_control_reg[`DF_TEST_HI:`DF_TEST_LO];
    wire              alt_bit_polarity    = data_format_control_reg[`DF_ABP_BIT];
    wire              randomizer_enable   = data_format_control_reg[`DF_RANDOMIZER_ENABLE_BIT];
    wire              twos_complement_sel = data_format_control_reg[`DF_TWOS_BIT];
    wire              phase_b             = phase_reg[1];
    wire              flip_msb;

    wire [DATA_W-1:0] coded;
    wire [DATA_W-1:0] scrambled;
    wire [DATA_W-1:0] polarised;

    wire              buf_ready;
    wire              buf_valid;
    wire [DATA_W:0]   buf_data;

    genvar            g;

    // One decode serves both the write strobe and the read multiplexer.
    function [1:0] reg_select;
        input [7:0] addr;
        begin
            case (addr)
                `OUTPUT_MODE_CFG_ADDR: begin
                    reg_select = SEL_MODE;
                end
                `DATA_FORMAT_CTRL_ADDR: begin
                    reg_select = SEL_FORMAT;
                end
                default: begin
                    reg_select = SEL_NONE;
                end
            endcase
        end
    endfunction

    // Register writes; unused bits are stored and read back but drive nothing.
    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            output_mode_cfg_reg     <= `OUTPUT_MODE_CFG_RST;
            data_format_control_reg <= `DATA_FORMAT_CTRL_RST;
        end else if (cfg_wr_i) begin
            case (reg_select(cfg_addr_i))
                SEL_MODE: begin
                    output_mode_cfg_reg <= cfg_wdata_i;
                end
                SEL_FORMAT: begin
                    data_format_control_reg <= cfg_wdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    always @* begin
        case (reg_select(cfg_addr_i))
            SEL_MODE: begin
                cfg_rdata_o = output_mode_cfg_reg;
            end
            SEL_FORMAT: begin
                cfg_rdata_o = data_format_control_reg;
            end
            default: begin
                cfg_rdata_o = 8'h00;
            end
        endcase
    end

    // Code 11 is passed through as it stands; nothing in this block decodes it.
    assign output_mode_o = {output_mode_sel_hi, output_mode_sel_lo};

    // The phase advances once per word accepted into the buffer, so a stall at the
    // receiver cannot make two words of one phase appear back to back.
    always @* begin
        phase_next = phase_reg;
        if (sample_valid_i && buf_ready) begin
            case (phase_reg)
                PHASE_A: begin
                    phase_next = PHASE_B;
                end
                PHASE_B: begin
                    phase_next = PHASE_A;
                end
                default: begin
                    phase_next = PHASE_A;
                end
            endcase
        end
    end

    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_reg <= PHASE_A;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Polarity mode overrides the coding select so the receiver sees offset binary.
    assign flip_msb = twos_complement_sel && !alt_bit_polarity;
    assign coded    = {sample_bits_i[DATA_W-1] ^ flip_msb, sample_bits_i[DATA_W-2:0]};

    // The least significant bit passes both stages untouched, because it is the
    // key that the receiver needs to undo the randomizer.
    assign scrambled[0] = coded[0];
    assign polarised[0] = scrambled[0];
    generate
        for (g = 1; g < DATA_W; g = g + 1) begin : g_data_bit
            assign scrambled[g] = coded[g] ^ (randomizer_enable && coded[0]);
            assign polarised[g] = scrambled[g] ^ (alt_bit_polarity && (g % 2 == 1));
        end
    endgenerate

    // Unused test codes fall back to normal data rather than a fixed word.
    always @* begin
        case (test_sel)
            `TEST_OFF: begin
                word_next = {overflow_flag_i, polarised};
            end
            `TEST_ZEROS: begin
                word_next = {(DATA_W+1){1'b0}};
            end
            `TEST_ONES: begin
                word_next = {(DATA_W+1){1'b1}};
            end
            `TEST_CHECKER: begin
                word_next = phase_b ? `CHECKER_B : `CHECKER_A;
            end
            `TEST_TOGGLE: begin
                word_next = {(DATA_W+1){phase_b}};
            end
            default: begin
                word_next = {overflow_flag_i, polarised};
            end
        endcase
    end

    out_skid_buffer #(
        .WIDTH (DATA_W+1)
    ) u_buf (
        .core_clk_i  (core_clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (buf_ready),
        .in_data_i   (word_next),
        .out_valid_o (buf_valid),
        .out_ready_i (word_ready_i),
        .out_data_o  (buf_data)
    );

    assign sample_ready_o = buf_ready;
    assign word_valid_o   = buf_valid;

    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sample_bits_o   <= {DATA_W{1'b0}};
            overflow_flag_o <= 1'b0;
        end else if (buf_valid && word_ready_i) begin
            {overflow_flag_o, sample_bits_o} <= buf_data;
        end
    end

    // Every pin carries its own enable, all taken from the one disable bit.
    generate
        for (g = 0; g <= DATA_W; g = g + 1) begin : g_pin_oe
            assign pin_oe_n_o[g] = output_disable;
        end
    endgenerate
endmodule // adc_output_format_control

/* tb/adc_fmt_monitor.sv */
// Port checker for the output formatting block.
`timescale 1ns/100ps
module adc_fmt_monitor (
    // Clock, reset, registers.
    input wire        core_clk_i,
    input wire        sys_rst_i,
    input wire [7:0]  cfg_addr_i,
    input wire        cfg_wr_i,
    input wire [7:0]  cfg_wdata_i,
    input wire [7:0]  cfg_rdata_o,
    // Words and pins.
    input wire        sample_ready_o,
    input wire [15:0] sample_bits_o,
    input wire        overflow_flag_o,
    input wire [16:0] pin_oe_n_o,
    input wire        word_valid_o,
    input wire        word_ready_i,
    input wire [1:0]  output_mode_o
);
    // The copy is only right while words drain before each rewrite.
    reg  [7:0]  fmt_reg;
    wire        pop = word_valid_o && word_ready_i;
    wire [16:0] w = {overflow_flag_o, sample_bits_o};
    wire        w3 = cfg_wr_i && cfg_addr_i == 8'h03;
    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            fmt_reg <= 8'h00;
        else if (cfg_wr_i && cfg_addr_i == 8'h04)
            fmt_reg <= cfg_wdata_i;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    AST_OE: assert property (w3 |=> pin_oe_n_o == {17{$past(cfg_wdata_i[2])}})
        else $error("oe");
    AST_MODE: assert property (w3 |=> output_mode_o == $past(cfg_wdata_i[1:0]))
        else $error("mode");
    AST_RDBK: assert property (w3 ##1 cfg_addr_i == 8'h03 |-> cfg_rdata_o == $past(cfg_wdata_i))
        else $error("readback");
    AST_ZERO: assert property (pop && fmt_reg[5:3] == 3'h1 |=> w == 17'h00000)
        else $error("zeros");
    AST_ONE: assert property (pop && fmt_reg[5:3] == 3'h3 |=> w == 17'h1ffff)
        else $error("ones");
    AST_CHK: assert property (pop && fmt_reg[5:3] == 3'h5 |=> w == 17'h15555 || w == 17'h0aaaa)
        else $error("checker");
    AST_TGL: assert property (pop && fmt_reg[5:3] == 3'h7 |=> w == 17'h00000 || w == 17'h1ffff)
        else $error("toggle");
    AST_FULL: assert property (!sample_ready_o |-> word_valid_o)
        else $error("full");
    AST_HOLD: assert property (!pop |=> $stable(w))
        else $error("word changed without a pop");
endmodule // adc_fmt_monitor
bind adc_output_format_control adc_fmt_monitor mon (
    .core_clk_i      (core_clk_i),
    .sys_rst_i       (sys_rst_i),
    .cfg_addr_i      (cfg_addr_i),
    .cfg_wr_i        (cfg_wr_i),
    .cfg_wdata_i     (cfg_wdata_i),
    .cfg_rdata_o     (cfg_rdata_o),
    .sample_ready_o  (sample_ready_o),
    .sample_bits_o   (sample_bits_o),
    .overflow_flag_o (overflow_flag_o),
    .pin_oe_n_o      (pin_oe_n_o),
    .word_valid_o    (word_valid_o),
    .word_ready_i    (word_ready_i),
    .output_mode_o   (output_mode_o)
);

/* tb/capture_model.sv */
// Capture-side model that keeps every word it takes.
`timescale 1ns/100ps
module capture_model (
    // Clock and reset.
    input  wire        core_clk_i,
    input  wire        sys_rst_i,
    // Words from the block.
    input  wire        word_valid_o,
    input  wire [15:0] sample_bits_o,
    input  wire        overflow_flag_o,
    output wire        word_ready_i,
    // Stall request.
    input  wire        hold_i
);
    // Pins load at the pop, so the word is taken one edge later.
    reg          took_reg;
    logic [16:0] got[$];
    assign word_ready_i = !hold_i;
    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (!sys_rst_i && took_reg)
            got.push_back({overflow_flag_o, sample_bits_o});
        took_reg <= !sys_rst_i && word_valid_o && word_ready_i;
    end
endmodule // capture_model

/* tb/adc_output_format_control_test.sv */
// Self-checking bench for the output formatting block.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module adc_output_format_control_test;
    reg         core_clk_i = 0;
    reg         sys_rst_i = 1;
    reg  [7:0]  cfg_addr_i = 8'h00;
    reg         cfg_wr_i = 0;
    reg  [7:0]  cfg_wdata_i = 8'h00;
    reg         sample_valid_i = 0;
    reg  [15:0] sample_bits_i = 16'h0000;
    reg         overflow_flag_i = 0;
    reg         hold = 0;
    reg         ph = 0;
    reg  [7:0]  cfg = 8'h00;
    reg  [7:0]  cfgs [0:9] = '{8'h00, 8'h01, 8'h05, 8'h02, 8'h07, 8'h08, 8'h18, 8'h28, 8'h38, 8'h10};
    wire [7:0]  cfg_rdata_o;
    wire [15:0] sample_bits_o;
    wire [16:0] pin_oe_n_o;
    wire [1:0]  output_mode_o;
    wire        sample_ready_o, overflow_flag_o, word_valid_o, word_ready_i;
    logic [16:0] exq[$];
    int failures = 0;
    int checked = 0;
    always #50 core_clk_i = ~core_clk_i;
    adc_output_format_control dut (.core_clk_i, .sys_rst_i, .cfg_addr_i, .cfg_wr_i,
        .cfg_wdata_i, .cfg_rdata_o, .sample_valid_i, .sample_ready_o, .sample_bits_i,
        .overflow_flag_i, .sample_bits_o, .overflow_flag_o, .pin_oe_n_o, .word_valid_o,
        .word_ready_i, .output_mode_o);
    capture_model cap (.core_clk_i, .sys_rst_i, .word_valid_o, .sample_bits_o,
        .overflow_flag_o, .word_ready_i, .hold_i(hold));
    function [16:0] fmt(input [16:0] w, input [7:0] c, input p);
        reg [15:0] d;
        d = w[15:0];
        if (c[0] && !c[2]) d[15] = ~d[15];
        if (c[1]) d[15:1] = d[15:1] ^ {15{d[0]}};
        if (c[2]) d = d ^ 16'haaaa;
        case (c[5:3])
            3'h1: fmt = 17'h00000;
            3'h3: fmt = 17'h1ffff;
            3'h5: fmt = p ? 17'h0aaaa : 17'h15555;
            3'h7: fmt = {17{p}};
            default: fmt = {w[16], d};
        endcase
    endfunction
    task wr(input [7:0] a, input [7:0] v);
        cfg_addr_i = a;
        cfg_wdata_i = v;
        cfg_wr_i = 1;
        @(negedge core_clk_i);
        cfg_wr_i = 0;
        if (a == 8'h04) cfg = v;
        @(negedge core_clk_i);
    endtask
    task rdchk(input [7:0] a, input [7:0] e);
        cfg_addr_i = a;
        #1;
        `CHK(cfg_rdata_o, e)
        @(negedge core_clk_i);
    endtask
    task send(input [16:0] w);
        sample_valid_i = 1;
        {overflow_flag_i, sample_bits_i} = w;
        while (sample_ready_o !== 1'b1) @(negedge core_clk_i);
        @(negedge core_clk_i);
        exq.push_back(fmt(w, cfg, ph));
        ph = ~ph;
    endtask
    task drain(input int t);
        sample_valid_i = 0;
        repeat (8) @(negedge core_clk_i);
        `CHK(cap.got.size(), exq.size())
        foreach (exq[i]) `CHK(cap.got[i], exq[i])
        exq.delete();
        cap.got.delete();
        $display("test %0d done", t);
    endtask
    task stop_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge core_clk_i);
        sys_rst_i = 0;
        rdchk(8'h04, 8'h00);
        `CHK(pin_oe_n_o, 17'h00000)
        for (int m = 0; m < 4; m++) begin
            wr(8'h03, m[7:0]);
            `CHK(output_mode_o, m[1:0])
        end
        // A configuring party would also put the core to sleep or nap here.
        wr(8'h03, 8'h04);
        `CHK(pin_oe_n_o, 17'h1ffff)
        wr(8'h07, 8'h5a);
        rdchk(8'h07, 8'h00);
        rdchk(8'h03, 8'h04);
        for (int i = 0; i < 10; i++) begin
            hold = (i == 0);
            wr(8'h04, cfgs[i]);
            rdchk(8'h04, cfgs[i]);
            send(17'h08001);
            send(17'h13c5a);
            `CHK(sample_ready_o, hold ? 1'b0 : 1'b1)
            hold = 0;
            send(17'h0ffff);
            drain(i);
        end
        stop_test;
    end
    initial begin
        #1000000;
        failures++;
        stop_test;
    end
endmodule // adc_output_format_control_test
